// >>> seeprm_dev.sv
// Device end: command decoder, 128x16 array, self-timed programming.
// Assumes link pins are asynchronous; sampled by two flops here.
// Functional notes
// RULE1 - Array is 128 words of 16 bits
// RULE2 - Commands start after first leading one
// RULE3 - Ten bits: opcode then address, MSB first
// RULE4 - 10 read, 01 write, 11 erase
// RULE5 - Opcode 00 extended by upper address bits
// RULE6 - Extended 00 disables programming
// RULE7 - Read outputs dummy zero then sixteen bits
// RULE8 - Output changes on rising shift clock
// RULE9 - Programming disabled after reset
// RULE10 - Enable persists until disable command
// RULE11 - Erase sets addressed word to ones
// RULE12 - Erase starts on chip select fall
// RULE13 - Writes take sixteen data bits MSB first
// RULE14 - Host drops select after last data bit
// RULE15 - Select high while programming shows status
// RULE16 - Select low resets command registers
// RULE17 - Erase-all sets every word to ones
// RULE18 - Fill-all stores pattern into every word
// RULE19 - Host should disable after programming
// RULE20 - Read works regardless of enable state
// RULE21 - Write needs no prior erase
// RULE22 - Programming cycle bounded, commands blocked meanwhile
// RULE23 - Output released while select low
`timescale 1ns/100ps
module seeprm_dev
	import seeprm_pkg::*;
#(
	parameter int PROG_CYCLES = PROG_CYC
) (
	input  wire logic i_clk,
	input  wire logic i_resetn,
	seeprm_if.dev     link,
	output logic      o_busy,
	output logic      o_prog_en
);
	typedef enum logic [2:0] {
		SEEPRM_IDLE = 3'h0,
		SEEPRM_CMD  = 3'h1,
		SEEPRM_DATA = 3'h2,
		SEEPRM_READ = 3'h3,
		SEEPRM_DONE = 3'h4
	} seeprm_state_t;

	logic [WORD_W-1:0] mem [WORDS];                    // RULE1
	logic [2:0]        cs_sync_reg;
	logic [2:0]        sk_sync_reg;
	logic [1:0]        di_sync_reg;
	logic              cs_s;
	logic              sk_rise;
	logic              cs_fall;
	logic              di_s;
	seeprm_state_t     state_reg;
	logic [3:0]        cnt_reg;
	logic [CMD_BITS-1:0] cmd_reg;
	logic [WORD_W-1:0] shreg;
	logic [WORD_W-1:0] data_reg;
	logic              pend_reg;
	logic [CMD_BITS-1:0] job_reg;
	logic [31:0]       timer_reg;
	logic              busy_reg;
	logic              en_reg;
	logic              do_reg;
	logic              oen_reg;
	logic [1:0]        op;
	logic [6:0]        addr;
	logic [1:0]        ext;
	int                i;

	assign cs_s    = cs_sync_reg[1];
	assign sk_rise = sk_sync_reg[1] && !sk_sync_reg[2];
	assign cs_fall = !cs_sync_reg[1] && cs_sync_reg[2];
	assign di_s    = di_sync_reg[1];
	assign op      = cmd_reg[9:8];
	assign addr    = job_reg[6:0];                      // RULE3
	assign ext     = cmd_reg[7:6];

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			cs_sync_reg <= 3'h0;
			sk_sync_reg <= 3'h0;
			di_sync_reg <= 2'h0;
		end else begin
			cs_sync_reg <= {cs_sync_reg[1:0], link.cs};
			sk_sync_reg <= {sk_sync_reg[1:0], link.shift_clock};
			di_sync_reg <= {di_sync_reg[0], link.serial_in};
		end
	end

	// Command shifting; low select clears state, bit count and command
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			state_reg <= SEEPRM_IDLE;
			cnt_reg   <= 4'h0;
			cmd_reg   <= '0;
			shreg     <= '0;
			data_reg  <= '0;
		end else if (!cs_s) begin
			state_reg <= SEEPRM_IDLE;                       // RULE16
			cnt_reg   <= 4'h0;
			cmd_reg   <= '0;
		end else if (sk_rise && !busy_reg) begin        // RULE22
			unique case (state_reg)
				SEEPRM_IDLE: begin
					if (di_s)
						state_reg <= SEEPRM_CMD;                // RULE2
				end
				SEEPRM_CMD: begin
					cmd_reg <= {cmd_reg[CMD_BITS-2:0], di_s};   // RULE3
					cnt_reg <= cnt_reg + 4'h1;
					if (cnt_reg == 4'(CMD_BITS-1)) begin
						cnt_reg <= 4'h0;
						if (cmd_reg[8:7] == OP_READ) begin      // RULE4
							state_reg <= SEEPRM_READ;           // RULE20
							shreg     <= mem[{cmd_reg[5:0], di_s}];  // RULE7
						end else if (cmd_reg[8:7] == OP_WRITE ||
								(cmd_reg[8:7] == OP_EXT && cmd_reg[6:5] == EXT_FILL))
							state_reg <= SEEPRM_DATA;           // RULE13
						else
							state_reg <= SEEPRM_DONE;
					end
				end
				SEEPRM_DATA: begin
					data_reg <= {data_reg[WORD_W-2:0], di_s};   // RULE13
					cnt_reg  <= cnt_reg + 4'h1;
					if (cnt_reg == 4'hf)
						state_reg <= SEEPRM_DONE;
				end
				SEEPRM_READ: begin
					shreg <= {shreg[WORD_W-2:0], 1'b0};
				end
				SEEPRM_DONE: begin
					state_reg <= SEEPRM_DONE;                   // RULE14
				end
				default: state_reg <= SEEPRM_IDLE;
			endcase
		end
	end

	// Serial output: dummy zero on the edge that takes the last address bit, then data
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			do_reg  <= 1'b1;
			oen_reg <= 1'b1;
		end else if (!cs_s) begin
			oen_reg <= 1'b1;                                // RULE23
			do_reg  <= 1'b1;
		end else if (busy_reg || pend_reg) begin
			oen_reg <= 1'b0;                                // RULE15
			do_reg  <= 1'b0;
		end else if (state_reg == SEEPRM_READ && sk_rise) begin
			oen_reg <= 1'b0;
			do_reg  <= shreg[WORD_W-1];                     // RULE8
		end else if (state_reg == SEEPRM_CMD && sk_rise && cnt_reg == 4'(CMD_BITS-1)
				&& cmd_reg[8:7] == OP_READ) begin
			oen_reg <= 1'b0;
			do_reg  <= 1'b0;                                // RULE7
		end else if (state_reg == SEEPRM_IDLE && timer_reg == 32'h0 && oen_reg == 1'b0) begin
			do_reg  <= 1'b1;                                // RULE15
		end
	end

	// Program enable latch and programming trigger
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			en_reg   <= 1'b0;                               // RULE9
			pend_reg <= 1'b0;
			job_reg  <= '0;
		end else begin
			pend_reg <= 1'b0;
			if (cs_fall && state_reg == SEEPRM_DONE && !busy_reg) begin  // RULE12
				// Kept: low select wipes cmd_reg before the array update
				job_reg <= cmd_reg;
				if (op == OP_EXT && ext == EXT_ENABLE)      // RULE5
					en_reg <= 1'b1;                         // RULE10
				else if (op == OP_EXT && ext == EXT_DISABLE)
					en_reg <= 1'b0;                         // RULE6
				else if (en_reg)
					pend_reg <= 1'b1;                       // RULE9
			end
		end
	end

	// Self-timed cycle; whole-array ops take one cycle too
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			busy_reg  <= 1'b0;
			timer_reg <= 32'h0;
		end else if (pend_reg) begin
			busy_reg  <= 1'b1;
			timer_reg <= 32'(PROG_CYCLES - 1);              // RULE22
		end else if (busy_reg) begin
			if (timer_reg == 32'h0)
				busy_reg <= 1'b0;
			else
				timer_reg <= timer_reg - 32'h1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (pend_reg) begin
			if (job_reg[9:8] == OP_WRITE)
				mem[addr] <= data_reg;                      // RULE21
			else if (job_reg[9:8] == OP_ERASE)
				mem[addr] <= ERASED_WORD;                   // RULE11
			else
				for (i = 0; i < WORDS; i++)
					mem[i] <= (job_reg[7:6] == EXT_FILL) ? data_reg : ERASED_WORD;  // RULE17 RULE18
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_busy    <= 1'b0;
			o_prog_en <= 1'b0;
		end else begin
			o_busy    <= busy_reg;
			o_prog_en <= en_reg;
		end
	end

	assign link.do_out   = do_reg;
	assign link.do_oen_n = oen_reg;
endmodule : seeprm_dev

// >>> seeprm_pkg.sv
// Package: shared constants for the serial EEPROM command port.
// Assumes both ends run on a 200 MHz system clock.
package seeprm_pkg;
	localparam int          CLK_PERIOD_NS   = 5;
	localparam int          WORD_W          = 16;
	localparam int          WORDS           = 128;
	localparam int          ADDR_W          = 8;
	localparam int          CMD_BITS        = 10;
	localparam int          CS_LOW_NS       = 250;
	localparam int          CS_LOW_CYC      = (CS_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          PROG_MS         = 10;
	localparam int          PROG_CYC        = PROG_MS * 1000000 / CLK_PERIOD_NS;
	localparam int          SK_HALF_NS      = 500;
	localparam int          SK_HALF_CYC     = SK_HALF_NS / CLK_PERIOD_NS;
	localparam logic [1:0]  OP_EXT          = 2'h0;
	localparam logic [1:0]  OP_WRITE        = 2'h1;
	localparam logic [1:0]  OP_READ         = 2'h2;
	localparam logic [1:0]  OP_ERASE        = 2'h3;
	localparam logic [1:0]  EXT_DISABLE     = 2'h0;
	localparam logic [1:0]  EXT_FILL        = 2'h1;
	localparam logic [1:0]  EXT_ERASE_ALL   = 2'h2;
	localparam logic [1:0]  EXT_ENABLE      = 2'h3;
	localparam logic [15:0] ERASED_WORD     = 16'hffff;
endpackage : seeprm_pkg

// >>> seeprm_if.sv
// Interface: three-wire serial link plus data output with enable.
// Assumes the host end resolves the data line from do_oen_n.
`timescale 1ns/100ps
interface seeprm_if;
	logic cs;
	logic shift_clock;
	logic serial_in;
	logic do_out;
	logic do_oen_n;
	modport dev  (input cs, input shift_clock, input serial_in, output do_out, output do_oen_n);
	modport host (output cs, output shift_clock, output serial_in, input do_out, input do_oen_n);
endinterface : seeprm_if

// >>> seeprm_fifo.sv
// FIFO: parameterised valid/ready buffer.
// Assumes one clock domain.
`timescale 1ns/100ps
module seeprm_fifo #(
	parameter int WIDTH = 28,
	parameter int DEPTH = 8
) (
	input  wire logic             i_clk,
	input  wire logic             i_resetn,
	input  wire logic             i_in_valid,
	output logic                  o_in_ready,
	input  wire logic [WIDTH-1:0] i_in_data,
	output logic                  o_out_valid,
	input  wire logic             i_out_ready,
	output logic [WIDTH-1:0]      o_out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_reg;
	logic [AW-1:0]    rd_reg;
	logic [AW:0]      cnt_reg;
	logic [AW:0]      cnt_next;
	logic             ready_reg;
	logic             push;
	logic             pop;
	assign push        = i_in_valid && o_in_ready;
	assign pop         = o_out_valid && i_out_ready;
	// Registered so the request handshake leaves a flop
	assign o_in_ready  = ready_reg;
	assign cnt_next    = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
	assign o_out_valid = cnt_reg != '0;
	assign o_out_data  = mem[rd_reg];
	always_ff @(posedge i_clk) begin
		if (push)
			mem[wr_reg] <= i_in_data;
	end
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			wr_reg  <= '0;
			rd_reg  <= '0;
			cnt_reg <= '0;
			ready_reg <= 1'b1;
		end else begin
			ready_reg <= cnt_next != (AW+1)'(DEPTH);
			if (push)
				wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
			if (pop)
				rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
			cnt_reg <= cnt_next;
		end
	end
endmodule : seeprm_fifo

// >>> seeprm_host.sv
// Host end: queues commands, shifts them out, returns read words.
// Assumes the device end is joined through seeprm_if.
`timescale 1ns/100ps
module seeprm_host
	import seeprm_pkg::*;
(
	input  wire logic        i_clk,
	input  wire logic        i_resetn,
	seeprm_if.host           link,
	input  wire logic        i_req_valid,
	output logic             o_req_ready,
	input  wire logic [1:0]  i_req_op,
	input  wire logic [7:0]  i_req_addr,
	input  wire logic [15:0] i_req_data,
	output logic             o_rd_valid,
	output logic [15:0]      o_rd_data,
	output logic             o_idle
);
	typedef enum logic [2:0] {
		SEEPRMH_IDLE  = 3'h0,
		SEEPRMH_SHIFT = 3'h1,
		SEEPRMH_GAP   = 3'h2,
		SEEPRMH_POLL  = 3'h3,
		SEEPRMH_LOW   = 3'h4
	} seeprmh_state_t;

	logic              f_valid;
	logic              f_ready;
	logic [25:0]       f_data;
	logic [1:0]        do_sync_reg;
	seeprmh_state_t    state_reg;
	logic [43:0]       tx_reg;
	logic [5:0]        bits_reg;
	logic [5:0]        total_reg;
	logic [7:0]        div_reg;
	logic              sk_reg;
	logic              cs_reg;
	logic              rd_reg;
	logic              prog_reg;
	logic [15:0]       rx_reg;
	logic [5:0]        rx_cnt_reg;

	seeprm_fifo #(.WIDTH(26), .DEPTH(8)) u_fifo (
		.i_clk       (i_clk),
		.i_resetn    (i_resetn),
		.i_in_valid  (i_req_valid),
		.o_in_ready  (o_req_ready),
		.i_in_data   ({i_req_op, i_req_addr, i_req_data}),
		.o_out_valid (f_valid),
		.i_out_ready (f_ready),
		.o_out_data  (f_data)
	);
	assign f_ready = state_reg == SEEPRMH_IDLE;

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn)
			do_sync_reg <= 2'h0;
		else
			do_sync_reg <= {do_sync_reg[0], link.do_out || link.do_oen_n};
	end

	// Start bit, opcode, address and optional data, MSB first
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			state_reg  <= SEEPRMH_IDLE;
			tx_reg     <= '0;
			bits_reg   <= 6'h0;
			total_reg  <= 6'h0;
			div_reg    <= 8'h0;
			sk_reg     <= 1'b0;
			cs_reg     <= 1'b0;
			rd_reg     <= 1'b0;
			prog_reg   <= 1'b0;
			rx_reg     <= '0;
			rx_cnt_reg <= 6'h0;
			o_rd_valid <= 1'b0;
			o_rd_data  <= 16'h0000;
		end else begin
			o_rd_valid <= 1'b0;
			unique case (state_reg)
				SEEPRMH_IDLE: begin
					div_reg <= 8'h0;
					if (f_valid) begin
						cs_reg     <= 1'b1;
						tx_reg     <= {1'b1, f_data[25:24], f_data[23:16], f_data[15:0], 17'h0};
						rd_reg     <= f_data[25:24] == OP_READ;
						prog_reg   <= !(f_data[25:24] == OP_READ ||
							(f_data[25:24] == OP_EXT && f_data[23:22] != EXT_ERASE_ALL
							&& f_data[23:22] != EXT_FILL));
						total_reg  <= (f_data[25:24] == OP_WRITE ||
							(f_data[25:24] == OP_EXT && f_data[23:22] == EXT_FILL)) ? 6'd27 :
							(f_data[25:24] == OP_READ) ? 6'd28 : 6'd11;
						bits_reg   <= 6'h0;
						rx_cnt_reg <= 6'h0;
						state_reg  <= SEEPRMH_SHIFT;
					end
				end
				SEEPRMH_SHIFT: begin
					div_reg <= div_reg + 8'h1;
					if (div_reg == 8'(SK_HALF_CYC - 1)) begin
						div_reg <= 8'h0;
						sk_reg  <= !sk_reg;
						if (sk_reg) begin
							tx_reg   <= {tx_reg[42:0], 1'b0};
							bits_reg <= bits_reg + 6'h1;
							if (bits_reg == total_reg - 6'h1)
								state_reg <= SEEPRMH_GAP;
						end else if (rd_reg && bits_reg > 6'd11) begin
							rx_reg     <= {rx_reg[14:0], do_sync_reg[1]};
							rx_cnt_reg <= rx_cnt_reg + 6'h1;
						end
					end
				end
				SEEPRMH_GAP: begin
					cs_reg  <= 1'b0;                        // RULE14
					sk_reg  <= 1'b0;
					div_reg <= div_reg + 8'h1;
					if (rd_reg && div_reg == 8'h0) begin
						o_rd_valid <= 1'b1;
						o_rd_data  <= rx_reg;
					end
					if (div_reg == 8'(CS_LOW_CYC + 2)) begin
						div_reg   <= 8'h0;
						cs_reg    <= prog_reg;
						state_reg <= prog_reg ? SEEPRMH_POLL : SEEPRMH_IDLE;
					end
				end
				SEEPRMH_POLL: begin
					div_reg <= div_reg + 8'h1;
					if (div_reg == 8'hff && do_sync_reg[1]) begin
						cs_reg    <= 1'b0;
						div_reg   <= 8'h0;
						state_reg <= SEEPRMH_LOW;
					end
				end
				SEEPRMH_LOW: begin
					div_reg <= div_reg + 8'h1;
					if (div_reg == 8'(CS_LOW_CYC + 2))
						state_reg <= SEEPRMH_IDLE;
				end
				default: state_reg <= SEEPRMH_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn)
			o_idle <= 1'b1;
		else
			o_idle <= state_reg == SEEPRMH_IDLE && !f_valid;
	end

	assign link.cs          = cs_reg;
	assign link.shift_clock = sk_reg;
	assign link.serial_in   = tx_reg[43];
endmodule : seeprm_host

// >>> seeprm_sva.sv
// Checker: link timing between host end and device end.
// Assumes both ends share i_clk; sits beside the link interface.
`timescale 1ns/100ps
module seeprm_sva
	import seeprm_pkg::*;
#(
	parameter int PROG_CYCLES = 200
) (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic cs,
	input wire logic shift_clock,
	input wire logic serial_in,
	input wire logic do_out,
	input wire logic do_oen_n,
	input wire logic o_busy,
	input wire logic o_prog_en
);
	logic        sk_reg;
	logic        sk_rise;
	logic [3:0]  sk_age_reg;
	logic [4:0]  bit_cnt_reg;
	logic [10:0] cmd_reg;
	logic        rd_frame_reg;
	logic [5:0]  cs_low_reg;
	int          busy_cnt_reg;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_resetn);

	assign sk_rise = shift_clock && !sk_reg;

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			sk_reg     <= 1'b0;
			sk_age_reg <= 4'hf;
		end else begin
			sk_reg     <= shift_clock;
			sk_age_reg <= sk_rise ? 4'h0 : ((sk_age_reg == 4'hf) ? 4'hf : sk_age_reg + 4'h1);
		end
	end

	// Start bit ends up at the top after eleven bits
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			bit_cnt_reg  <= 5'h00;
			cmd_reg      <= 11'h000;
			rd_frame_reg <= 1'b0;
		end else if (!cs) begin
			bit_cnt_reg  <= 5'h00;
			rd_frame_reg <= 1'b0;
		end else if (sk_rise) begin
			// Reads need one extra clock to take the last data bit
			if (bit_cnt_reg == 5'd11)
				rd_frame_reg <= cmd_reg[9:8] == OP_READ;
			bit_cnt_reg <= bit_cnt_reg + 5'h01;
			cmd_reg     <= {cmd_reg[9:0], serial_in};
		end
	end

	// Reset counts as a long select-low period
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			cs_low_reg <= 6'h3f;
		end else if (cs) begin
			cs_low_reg <= 6'h00;
		end else if (cs_low_reg != 6'h3f) begin
			cs_low_reg <= cs_low_reg + 6'h01;
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			busy_cnt_reg <= 0;
		end else begin
			busy_cnt_reg <= o_busy ? busy_cnt_reg + 1 : 0;
		end
	end

	property p_release;
		(!cs) [*4] |-> do_oen_n;
	endproperty
	a_release: assert property (p_release) else $error("output driven with select low");
	property p_on_sk;
		cs && $past(cs, 3) && !do_oen_n && !$past(do_oen_n, 3) && $changed(do_out) && !o_busy
			&& !$past(o_busy, 6) |-> sk_age_reg <= 4'd6;
	endproperty
	a_on_sk: assert property (p_on_sk) else $error("output moved without rising shift clock");
	property p_busy_low;
		o_busy && $past(o_busy, 4) && !do_oen_n && $past(!do_oen_n, 2) |-> !do_out;
	endproperty
	a_busy_low: assert property (p_busy_low) else $error("status not low while busy");
	property p_ready;
		$fell(o_busy) && cs && !do_oen_n |-> ##[0:6] do_out;
	endproperty
	a_ready: assert property (p_ready) else $error("status not high after cycle");
	property p_prog_time;
		$fell(o_busy) |-> busy_cnt_reg >= PROG_CYCLES - 2 && busy_cnt_reg <= PROG_CYCLES + 2;
	endproperty
	a_prog_time: assert property (p_prog_time) else $error("programming length wrong");
	property p_prog_start;
		$rose(o_busy) |-> !cs && o_prog_en && cs_low_reg <= 6'd8;
	endproperty
	a_prog_start: assert property (p_prog_start) else $error("programming started wrongly");
	property p_enable_edge;
		$changed(o_prog_en) |-> !cs && cs_low_reg <= 6'd8;
	endproperty
	a_enable_edge: assert property (p_enable_edge) else $error("enable moved outside select fall");
	property p_cs_low;
		$rose(cs) |-> cs_low_reg >= CS_LOW_CYC;
	endproperty
	a_cs_low: assert property (p_cs_low) else $error("select low time too short");
	property p_frame_len;
		sk_rise && cs |-> bit_cnt_reg < (rd_frame_reg ? 5'd28 : 5'd27);
	endproperty
	a_frame_len: assert property (p_frame_len) else $error("too many clocks in frame");
	property p_dummy;
		cs && bit_cnt_reg == 5'd11 && cmd_reg[9:8] == OP_READ && sk_age_reg == 4'd8 |-> !do_oen_n && !do_out;
	endproperty
	a_dummy: assert property (p_dummy) else $error("no leading zero on read");

	c_read: cover property (cs && bit_cnt_reg == 5'd11 && cmd_reg[9:8] == OP_READ && sk_age_reg == 4'd8);
	c_prog: cover property ($rose(o_busy));
	c_ready: cover property ($fell(o_busy) && cs);
endmodule : seeprm_sva

// >>> seeprm_tb.sv
// Testbench: host end drives device end over the link.
// Assumes a short programming time so the run stays brief.
`timescale 1ns/100ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin failures++; $display("[FAIL] %0t got=%h exp=%h", $time, got, exp); end end
module seeprm_tb
	import seeprm_pkg::*;
;
	localparam int PROG = 200;
	logic        i_clk     = 1'b0;
	logic        i_resetn  = 1'b0;
	logic        req_valid = 1'b0;
	logic [1:0]  req_op    = 2'h0;
	logic [7:0]  req_addr  = 8'h00;
	logic [15:0] req_data  = 16'h0000;
	logic        req_ready;
	logic        rd_valid;
	logic        host_idle;
	logic        busy;
	logic        prog_en;
	logic [15:0] rd_data;
	logic        busy_q    = 1'b0;
	logic        refused   = 1'b0;
	int          failures  = 0;
	int          checks    = 0;
	int          busy_rises = 0;
	logic [15:0] rd_q[$];

	seeprm_if link();
	seeprm_dev #(.PROG_CYCLES(PROG)) i_seeprm_dev (.i_clk(i_clk), .i_resetn(i_resetn), .link(link),
		.o_busy(busy), .o_prog_en(prog_en));
	seeprm_host i_seeprm_host (.i_clk(i_clk), .i_resetn(i_resetn), .link(link), .i_req_valid(req_valid),
		.o_req_ready(req_ready), .i_req_op(req_op), .i_req_addr(req_addr), .i_req_data(req_data),
		.o_rd_valid(rd_valid), .o_rd_data(rd_data), .o_idle(host_idle));
	seeprm_sva #(.PROG_CYCLES(PROG)) i_seeprm_sva (.i_clk(i_clk), .i_resetn(i_resetn), .cs(link.cs),
		.shift_clock(link.shift_clock), .serial_in(link.serial_in), .do_out(link.do_out),
		.do_oen_n(link.do_oen_n), .o_busy(busy), .o_prog_en(prog_en));

	always #2.5 i_clk = ~i_clk;

	// Falling edge: registered outputs have settled
	always @(negedge i_clk) begin
		if (busy === 1'b1 && busy_q === 1'b0) begin
			busy_rises++;
		end
		busy_q = busy;
		if (rd_valid === 1'b1) begin
			rd_q.push_back(rd_data);
		end
	end

	task automatic complete_run();
		$display("checks=%0d failures=%0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : complete_run

	task automatic push(input logic [1:0] op, input logic [7:0] addr, input logic [15:0] data);
		int n;
		@(negedge i_clk);
		req_valid = 1'b1;
		req_op    = op;
		req_addr  = addr;
		req_data  = data;
		for (n = 0; n < 60000 && req_ready !== 1'b1; n++) begin
			refused = 1'b1;
			@(negedge i_clk);
		end
		if (n == 60000) begin
			failures++;
			complete_run();
		end
		@(negedge i_clk);
		req_valid = 1'b0;
	endtask : push

	task automatic wait_idle();
		int n;
		repeat (4) @(negedge i_clk);
		for (n = 0; n < 90000 && host_idle !== 1'b1; n++) begin
			@(negedge i_clk);
		end
		if (n == 90000) begin
			failures++;
			complete_run();
		end
	endtask : wait_idle

	task automatic expect_rd(input logic [15:0] exp);
		logic [15:0] got;
		got = (rd_q.size() > 0) ? rd_q.pop_front() : 16'hxxxx;
		`CHK(got, exp)
	endtask : expect_rd

	task automatic t_reset();
		`CHK(prog_en, 1'b0)
		`CHK(host_idle, 1'b1)
		`CHK(link.do_oen_n, 1'b1)
		$display("t_reset done");
	endtask : t_reset

	task automatic t_guard();
		push(OP_EXT, {EXT_ENABLE, 6'h00}, 16'h0000);
		push(OP_EXT, {EXT_ERASE_ALL, 6'h2a}, 16'h0000);
		push(OP_READ, 8'h00, 16'h0000);
		push(OP_EXT, {EXT_DISABLE, 6'h15}, 16'h0000);
		push(OP_WRITE, 8'h05, 16'h1234);
		push(OP_READ, 8'h05, 16'h0000);
		wait_idle();
		expect_rd(ERASED_WORD);
		expect_rd(ERASED_WORD);
		`CHK(busy_rises, 1)
		`CHK(prog_en, 1'b0)
		$display("t_guard done");
	endtask : t_guard

	task automatic t_burst();
		int base;
		base    = busy_rises;
		refused = 1'b0;
		push(OP_EXT, {EXT_ENABLE, 6'h3f}, 16'h0000);
		push(OP_WRITE, 8'h05, 16'h1234);
		push(OP_WRITE, 8'h85, 16'ha5c3);
		push(OP_READ, 8'h05, 16'h0000);
		push(OP_READ, 8'h06, 16'h0000);
		push(OP_ERASE, 8'h05, 16'h0000);
		push(OP_READ, 8'h85, 16'h0000);
		push(OP_EXT, {EXT_FILL, 6'h01}, 16'h0f0f);
		push(OP_READ, 8'h00, 16'h0000);
		push(OP_READ, 8'h7f, 16'h0000);
		push(OP_READ, 8'h06, 16'h0000);
		`CHK(refused, 1'b1)
		wait_idle();
		expect_rd(16'ha5c3);
		expect_rd(ERASED_WORD);
		expect_rd(ERASED_WORD);
		expect_rd(16'h0f0f);
		expect_rd(16'h0f0f);
		expect_rd(16'h0f0f);
		`CHK(busy_rises - base, 4)
		`CHK(prog_en, 1'b1)
		$display("t_burst done");
	endtask : t_burst

	task automatic t_lock();
		int base;
		base = busy_rises;
		push(OP_EXT, {EXT_DISABLE, 6'h00}, 16'h0000);
		push(OP_EXT, {EXT_ERASE_ALL, 6'h00}, 16'h0000);
		push(OP_ERASE, 8'h00, 16'h0000);
		push(OP_READ, 8'h00, 16'h0000);
		wait_idle();
		expect_rd(16'h0f0f);
		`CHK(busy_rises - base, 0)
		`CHK(rd_q.size(), 0)
		$display("t_lock done");
	endtask : t_lock

	initial begin
		repeat (20) @(negedge i_clk);
		i_resetn = 1'b1;
		t_reset();
		t_guard();
		t_burst();
		t_lock();
		complete_run();
	end
endmodule : seeprm_tb
